// file: inc/bpb_pkg.sv
// Behaviour
// - PWM frequency comes from a 5-bit frequency code, scaled by the clock multiplier.
// - A 2-bit code sets the generation clock to 5, 10, 20 or 40 MHz.
// - Each doubling of the generation clock doubles the frequency for a code.
// - With source select at 0 the resistor band picks the frequency instead.
// - Phase shifting works only while its enable bit is 1.
// - Shifted outputs start one quarter period after the previous output.
// - With phase shift off, all four outputs switch together.
// - Dither applies only while sloping between values with slope enabled.
// - Once settled at target, dither stops and all pulses are equal.
// - A 4-bit field sets transition time from 0 to 500 ms.
// - The same transition time is used up and down.
// - A 2-bit field sets zero to three dither bits.
// - With N dither bits the next N brightness bits set how many pulses in 2^N are one LSB longer.
// - A 3-bit field sets minimum headroom; boost target regulates to meet it.
// - Adaptive regulation moves the boost target in 125 mV steps.
// - The string with highest forward voltage is found and used as reference.
// - The 8x8-bit configuration store is read and written, effective immediately.
// - A 2-bit field selects boost switching from 156 kHz to 1.25 MHz.
// - With boost enable at 1, boost starts whenever backlight is enabled.
// - Adaptive mode has its own bit; starting adaptive loads the manual code.
// - Manual code n gives 10+n volts; codes 30 and 31 give 40 volts.
// - Brightness leaving the slope stage is 16 bits wide.
// - Direct mode disables phase shift, slope and dither; input is resampled.
package bpb_pkg;
    // Clocking
    localparam int BPB_CLK_MHZ = 250;
    localparam int BPB_INT_MHZ = 5;
    localparam int BPB_INT_HZ = BPB_INT_MHZ * 1000000;
    localparam int BPB_INT_DIV = BPB_CLK_MHZ / BPB_INT_MHZ;
    localparam logic [8:0] BPB_GEN_WRAP = 9'(BPB_CLK_MHZ);
    localparam int BPB_ADAPT_US = 100;
    localparam int BPB_ADAPT_TICKS = BPB_ADAPT_US * BPB_INT_MHZ;
    localparam int BPB_BSW_DIV = 4;
    localparam int BPB_BRIGHT_FS = 65536;
    // Register byte addresses
    localparam logic [5:0] BPB_TARGET_OFS = 6'h20;
    localparam logic [5:0] BPB_STATUS_OFS = 6'h24;
    // Configuration bytes and field positions
    localparam int BPB_B_PWM = 0;
    localparam int BPB_F_CODE = 0;
    localparam int BPB_F_MULT = 5;
    localparam int BPB_F_SRC = 7;
    localparam int BPB_B_CTL = 1;
    localparam int BPB_F_PSE = 0;
    localparam int BPB_F_SLOPE = 1;
    localparam int BPB_F_DITH = 5;
    localparam int BPB_F_BEN = 7;
    localparam int BPB_B_BST = 2;
    localparam int BPB_F_VCODE = 0;
    localparam int BPB_F_HEAD = 5;
    localparam int BPB_B_BCTL = 3;
    localparam int BPB_F_BSW = 0;
    localparam int BPB_F_ADAPT = 2;
    localparam int BPB_F_MODE = 3;
    localparam logic [1:0] BPB_MODE_DIRECT = 2'h3;
    localparam logic [63:0] BPB_CFG_RESET = 64'h0000_0000_0000_0080;
    // Boost voltage scale
    localparam int BPB_STEP_MV = 125;
    localparam int BPB_UNITS_PER_V = 1000 / BPB_STEP_MV;
    localparam int BPB_VMIN_V = 10;
    localparam int BPB_VMAX_V = 40;
    localparam int BPB_HEAD_BASE_MV = 300;
    // Status field positions
    localparam int BPB_ST_VT = 16;
    localparam int BPB_ST_ON = 25;
    localparam int BPB_ST_SETTLED = 26;
    localparam int BPB_ST_DIRECT = 27;
    // Frequency at 5 MHz generation clock, per code
    localparam int BPB_FREQ_HZ [32] = '{
        601, 826, 1052, 1202, 1503, 1728, 1953, 2179,
        2404, 2554, 2705, 2855, 3005, 3155, 3306, 3456,
        3606, 3756, 3907, 4057, 4207, 4357, 4508, 4658,
        4808, 6386, 7963, 9616, 12020, 14424, 16828, 19232};
    // Resolution bits per code
    localparam int BPB_RES [32] = '{
        13, 12, 12, 12, 11, 11, 11, 11, 11, 10, 10, 10, 10, 10, 10, 10,
        10, 10, 10, 10, 10, 10, 10, 10, 10, 9, 9, 9, 8, 8, 8, 8};
    // Resistor band to frequency code, index is multiplier*8+band
    localparam int BPB_RSET_CODE [32] = '{
        31, 30, 29, 28, 27, 26, 25, 24,
        27, 26, 25, 24, 21, 18, 13, 8,
        24, 19, 16, 12, 8, 6, 4, 3,
        8, 7, 6, 4, 3, 2, 1, 0};
    // Transition time per slope code
    localparam int BPB_SLOPE_MS [16] = '{
        0, 1, 2, 5, 10, 20, 50, 75, 100, 150, 200, 250, 300, 350, 400, 500};
    typedef enum logic [0:0] {
        BPB_OFF = 1'b0,
        BPB_ON = 1'b1
    } bpb_boost_e;
endpackage

// file: hdl/bpb_channel.sv
`timescale 1ns/100ps
module bpb_channel
    import bpb_pkg::*;
(
    input wire logic clk_in,            // System clock
    input wire logic reset_in,          // Synchronous reset
    input wire logic [13:0] count_in,   // Shared period counter
    input wire logic [13:0] period_in,  // Period length in ticks
    input wire logic [13:0] offset_in,  // Phase delay in ticks
    input wire logic [13:0] duty_in,    // High time in ticks
    output logic led_out               // Channel PWM output
);
    import bpb_pkg::*;

    typedef struct packed {
        logic led;
    } bpb_chan_s;

    bpb_chan_s s;
    bpb_chan_s next_s;
    logic [14:0] pos;

    ////////////////////////////////////////////////////////////////
    // Position in the delayed period, wrapped
    always_comb begin
        if (count_in >= offset_in) begin
            pos = 15'(count_in - offset_in);
        end else begin
            pos = 15'(count_in) + 15'(period_in) - 15'(offset_in);
        end
        next_s.led = pos < 15'(duty_in);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign led_out = s.led;
endmodule

// file: hdl/bpb_top.sv
`timescale 1ns/100ps
module bpb_top
    import bpb_pkg::*;
(
    input wire logic clk_in,                       // 250 MHz clock
    input wire logic reset_in,                     // Synchronous reset
    input wire logic [5:0] avs_address_in,         // Byte address
    input wire logic avs_read_in,                  // Read request
    input wire logic avs_write_in,                 // Write request
    input wire logic [31:0] avs_writedata_in,      // Write data
    input wire logic [3:0] avs_byteenable_in,      // Byte lanes
    output logic [31:0] avs_readdata_out,          // Read data
    output logic avs_waitrequest_out,              // Stall
    input wire logic backlight_enable_in,          // Backlight on
    input wire logic [2:0] frequency_set_resistor_in, // Resistor band
    input wire logic pwm_direct_in,                // Direct PWM input
    input wire logic [3:0][11:0] led_headroom_mv_in, // Driver mV
    output logic [3:0] led_out,                    // LED channel PWM
    output logic boost_run_out,                    // Boost running
    output logic boost_clock_out,                  // Switch pulse
    output logic [8:0] boost_target_out            // 125 mV units
);
    import bpb_pkg::*;

    typedef struct packed {
        logic [7:0][7:0] cfg;
        logic [15:0] target;
        logic [15:0] bright;
        logic ack;
        logic [31:0] rdata;
        logic [5:0] div;
        logic [8:0] gacc;
        logic [13:0] cnt;
        logic [13:0] duty;
        logic ext;
        logic [2:0] pcnt;
        logic [5:0] scnt;
        logic [8:0] acnt;
        bpb_boost_e boost;
        logic [8:0] vt;
        logic [4:0] bdiv;
        logic bclk;
        logic direct;
        logic [3:0] led;
    } bpb_state_s;

    localparam bpb_state_s RST = '{
        cfg: BPB_CFG_RESET, boost: BPB_OFF, default: '0};
    localparam logic [8:0] VMIN_U = 9'(BPB_VMIN_V * BPB_UNITS_PER_V);
    localparam logic [8:0] VMAX_U = 9'(BPB_VMAX_V * BPB_UNITS_PER_V);

    bpb_state_s s;
    bpb_state_s next_s;

    logic int_tick;
    logic gen_tick;
    logic wrap;
    logic sloping;
    logic direct_mode;
    logic phase_on;
    logic run_req;
    logic adapt;
    logic [1:0] mult;
    logic [1:0] dbits;
    logic [3:0] slope;
    logic [4:0] code;
    logic [4:0] vcode;
    logic [8:0] gen_sum;
    logic [13:0] period;
    logic [4:0] res;
    logic [15:0] rem;
    logic [2:0] frac;
    logic [2:0] mask;
    logic [8:0] man_units;
    logic [11:0] thr_mv;
    logic [11:0] min_mv;
    logic [3:0] chan;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////
    // Ticks per brightness LSB for a slope code
    function automatic logic [5:0] slope_iv(input logic [3:0] c);
        int t;
        t = BPB_SLOPE_MS[c] * (BPB_INT_HZ / 1000) / BPB_BRIGHT_FS;
        if (t < 1) begin
            t = 1;
        end
        return 6'(t);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Configuration fields
    assign mult = s.cfg[BPB_B_PWM][BPB_F_MULT +: 2];
    assign slope = s.cfg[BPB_B_CTL][BPB_F_SLOPE +: 4];
    assign dbits = s.cfg[BPB_B_CTL][BPB_F_DITH +: 2];
    assign vcode = s.cfg[BPB_B_BST][BPB_F_VCODE +: 5];
    assign adapt = s.cfg[BPB_B_BCTL][BPB_F_ADAPT];
    assign direct_mode = s.cfg[BPB_B_BCTL][BPB_F_MODE +: 2] == BPB_MODE_DIRECT;
    // Phase shift only when enabled and not in direct mode
    assign phase_on = s.cfg[BPB_B_CTL][BPB_F_PSE] && !direct_mode;
    assign run_req = s.cfg[BPB_B_CTL][BPB_F_BEN] && backlight_enable_in;

    // Frequency code from the store or the resistor band
    assign code = s.cfg[BPB_B_PWM][BPB_F_SRC] ?
        s.cfg[BPB_B_PWM][BPB_F_CODE +: 5] :
        5'(BPB_RSET_CODE[{mult, frequency_set_resistor_in}]);

    // Period in generation ticks; same count at any multiplier
    assign period = 14'(BPB_INT_HZ / BPB_FREQ_HZ[code]);
    assign res = 5'(BPB_RES[code]);

    ////////////////////////////////////////////////////////////////
    // Clock enables: 5 MHz divider and generation clock accumulator
    assign int_tick = s.div == 6'(BPB_INT_DIV - 1);
    assign gen_sum = s.gacc + (9'h005 << mult);
    assign gen_tick = gen_sum >= BPB_GEN_WRAP;
    assign wrap = gen_tick && (s.cnt >= period - 14'h0001);

    ////////////////////////////////////////////////////////////////
    // Resolution selector and dither fraction
    assign sloping = slope != 4'h0 && !direct_mode &&
        s.bright != s.target;
    assign rem = 16'(s.bright << res);
    assign frac = rem[15:13] >> (2'h3 - dbits);
    assign mask = 3'((4'h1 << dbits) - 4'h1);

    ////////////////////////////////////////////////////////////////
    // Weakest string is the least headroom, highest forward voltage
    always_comb begin
        min_mv = led_headroom_mv_in[0];
        for (int i = 1; i < 4; i++) begin
            if (led_headroom_mv_in[i] < min_mv) begin
                min_mv = led_headroom_mv_in[i];
            end
        end
    end

    assign thr_mv = 12'(BPB_HEAD_BASE_MV + BPB_STEP_MV *
        int'(s.cfg[BPB_B_BST][BPB_F_HEAD +: 3]));
    assign man_units = vcode >= 5'h1e ? VMAX_U :
        9'((BPB_VMIN_V + int'(vcode)) * BPB_UNITS_PER_V);

    ////////////////////////////////////////////////////////////////
    // Read multiplexer
    always_comb begin
        rd_val = 32'h0000_0000;
        if (!avs_address_in[5] && avs_address_in[1:0] == 2'h0) begin
            rd_val = {24'h00_0000, s.cfg[avs_address_in[4:2]]};
        end else if (avs_address_in == BPB_TARGET_OFS) begin
            rd_val = {16'h0000, s.target};
        end else if (avs_address_in == BPB_STATUS_OFS) begin
            rd_val[15:0] = s.bright;
            rd_val[BPB_ST_VT +: 9] = s.vt;
            rd_val[BPB_ST_ON] = s.boost == BPB_ON;
            rd_val[BPB_ST_SETTLED] = s.bright == s.target;
            rd_val[BPB_ST_DIRECT] = direct_mode;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        next_s.bclk = 1'b0;
        // Bus: one wait cycle, then write or read completes
        next_s.ack = (avs_read_in || avs_write_in) && !s.ack;
        if (!s.ack) begin
            next_s.rdata = rd_val;
        end
        if (avs_write_in && s.ack) begin
            if (!avs_address_in[5] && avs_address_in[1:0] == 2'h0) begin
                if (avs_byteenable_in[0]) begin
                    next_s.cfg[avs_address_in[4:2]] =
                        avs_writedata_in[7:0];
                end
            end else if (avs_address_in == BPB_TARGET_OFS) begin
                if (avs_byteenable_in[0]) begin
                    next_s.target[7:0] = avs_writedata_in[7:0];
                end
                if (avs_byteenable_in[1]) begin
                    next_s.target[15:8] = avs_writedata_in[15:8];
                end
            end
        end

        // Timebases
        next_s.div = int_tick ? 6'h00 : 6'(s.div + 6'h01);
        next_s.gacc = gen_tick ? 9'(gen_sum - BPB_GEN_WRAP) : gen_sum;

        // Period counter; duty and dither latched at each wrap
        if (gen_tick) begin
            next_s.cnt = wrap ? 14'h0000 : 14'(s.cnt + 14'h0001);
            next_s.direct = pwm_direct_in;
        end
        if (wrap) begin
            next_s.duty = 14'(s.bright >> (5'h10 - res));
            next_s.pcnt = 3'(s.pcnt + 3'h1) & mask;
            next_s.ext = sloping && dbits != 2'h0 &&
                (s.pcnt & mask) < frac;
        end

        // Slope: one LSB per interval, both directions alike
        if (slope == 4'h0 || direct_mode) begin
            next_s.bright = s.target;
            next_s.scnt = 6'h00;
            next_s.ext = 1'b0;
        end else if (int_tick && s.bright != s.target) begin
            if (s.scnt >= slope_iv(slope) - 6'h01) begin
                next_s.scnt = 6'h00;
                if (s.bright < s.target) begin
                    next_s.bright = 16'(s.bright + 16'h0001);
                end else begin
                    next_s.bright = 16'(s.bright - 16'h0001);
                end
            end else begin
                next_s.scnt = 6'(s.scnt + 6'h01);
            end
        end

        // Adaptive update interval
        if (int_tick) begin
            next_s.acnt = s.acnt == 9'(BPB_ADAPT_TICKS - 1) ?
                9'h000 : 9'(s.acnt + 9'h001);
        end

        // Boost control
        case (s.boost)
            BPB_OFF: begin
                if (run_req) begin
                    next_s.boost = BPB_ON;
                    next_s.vt = man_units;
                    next_s.bdiv = 5'h00;
                end
            end
            BPB_ON: begin
                if (!run_req) begin
                    next_s.boost = BPB_OFF;
                end else begin
                    if (adapt && int_tick && s.acnt == 9'h000) begin
                        if (min_mv < thr_mv && s.vt < VMAX_U) begin
                            next_s.vt = 9'(s.vt + 9'h001);
                        end else if (13'(min_mv) >= 13'(thr_mv) +
                                13'(BPB_STEP_MV) && s.vt > VMIN_U) begin
                            next_s.vt = 9'(s.vt - 9'h001);
                        end
                    end
                    if (int_tick) begin
                        if (s.bdiv == 5'((BPB_BSW_DIV << s.cfg[BPB_B_BCTL][
                                BPB_F_BSW +: 2]) - 1)) begin
                            next_s.bdiv = 5'h00;
                            next_s.bclk = 1'b1;
                        end else begin
                            next_s.bdiv = 5'(s.bdiv + 5'h01);
                        end
                    end
                end
            end
            default: begin
                next_s.boost = BPB_OFF;
            end
        endcase
        if (!adapt) begin
            next_s.vt = man_units;
        end

        // Output selection
        next_s.led = direct_mode ? {4{s.direct}} : chan;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Four comparators, each delayed by a multiple of a quarter period
    for (genvar i = 0; i < 4; i++) begin : g_ch
        bpb_channel u_ch (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .count_in(s.cnt),
            .period_in(period),
            .offset_in(phase_on ? 14'((i * int'(period)) / 4) : 14'h0000),
            .duty_in(14'(s.duty + 14'(s.ext))),
            .led_out(chan[i])
        );
    end

    // Outputs
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !s.ack;
    assign avs_readdata_out = s.rdata;
    assign led_out = s.led;
    assign boost_run_out = s.boost == BPB_ON;
    assign boost_clock_out = s.bclk;
    assign boost_target_out = s.vt;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    property p_cfg_write;
        (avs_write_in && s.ack && avs_address_in == 6'h00 &&
            avs_byteenable_in[0]) |=> s.cfg[0] == $past(avs_writedata_in[7:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("cfg write lost");

    property p_dither_slope;
        s.ext |-> $past(slope) != 4'h0;
    endproperty
    a_dither_slope: assert property (p_dither_slope) else $error("dither no slope");

    property p_settled;
        (wrap && s.bright == s.target) |=> !s.ext;
    endproperty
    a_settled: assert property (p_settled) else $error("dither when settled");

    property p_no_shift;
        (!phase_on && !direct_mode)[*3] |-> chan == 4'h0 || chan == 4'hf;
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("outputs not aligned");

    property p_start_load;
        $rose(s.boost == BPB_ON) |-> s.vt == $past(man_units);
    endproperty
    a_start_load: assert property (p_start_load) else $error("bad start target");

    property p_step;
        (s.boost == BPB_ON && adapt && $past(adapt) && $past(s.boost) == BPB_ON &&
            s.vt != $past(s.vt)) |-> (s.vt == 9'($past(s.vt) + 9'h001) ||
            s.vt == 9'($past(s.vt) - 9'h001));
    endproperty
    a_step: assert property (p_step) else $error("adaptive step not 125 mV");

    property p_manual;
        (!adapt && !$past(reset_in)) |=> s.vt == $past(man_units) && s.vt <= VMAX_U;
    endproperty
    a_manual: assert property (p_manual) else $error("manual target wrong");

    property p_boost_stop;
        !run_req |=> s.boost == BPB_OFF;
    endproperty
    a_boost_stop: assert property (p_boost_stop) else $error("boost not stopped");

    property p_no_slope;
        (slope == 4'h0 || direct_mode) |=> s.bright == $past(s.target);
    endproperty
    a_no_slope: assert property (p_no_slope) else $error("slope when off");

    c_dither: cover property (s.ext);
    c_shift: cover property (phase_on && chan == 4'h1);
    c_up: cover property (adapt && s.vt == 9'($past(s.vt) + 9'h001));
endmodule

// file: verif/bpb_top_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end
module bpb_top_tb;
    import bpb_pkg::*;
    localparam int LIMIT = 95000;
    localparam int TGT = 32768;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [5:0] avs_address_in = 6'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic backlight_enable_in = 1'b0;
    logic [2:0] frequency_set_resistor_in = 3'h0;
    logic pwm_direct_in = 1'b0;
    logic [3:0] led_out;
    logic boost_run_out;
    logic boost_clock_out;
    logic [8:0] boost_target_out;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    bpb_top bpb_top_inst (.clk_in(clk_in), .reset_in(reset_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .backlight_enable_in(backlight_enable_in),
        .frequency_set_resistor_in(frequency_set_resistor_in), .pwm_direct_in(pwm_direct_in),
        .led_headroom_mv_in({4{12'h384}}), .led_out(led_out), .boost_run_out(boost_run_out),
        .boost_clock_out(boost_clock_out), .boost_target_out(boost_target_out));
    // Clock at 250 MHz
    always #2 clk_in = ~clk_in;
    // Hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bus cycles: request held until waitrequest is seen low at an edge
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        if (w) avs_write_in <= 1'b1;
        else avs_read_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask
    // Cycles between two boost switch pulses
    task automatic bclk(output int n);
        int k;
        k = 0;
        n = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (boost_clock_out !== 1'b1 && k < 5000);
        do begin
            @(negedge clk_in);
            n++;
        end while (boost_clock_out !== 1'b1 && n < 5000);
        @(posedge clk_in);
    endtask
    // One PWM period of channel 0: length, high time, skew and later channel rises
    task automatic meas(output int per, output int hi, output int neq, output int rs[4]);
        logic [3:0] p;
        int n;
        n = 0;
        per = 0;
        hi = 0;
        neq = 0;
        rs = '{0, 0, 0, 0};
        do begin
            p = led_out;
            @(negedge clk_in);
            n++;
        end while (!(led_out[0] === 1'b1 && p[0] === 1'b0) && n < 40000);
        do begin
            p = led_out;
            @(negedge clk_in);
            per++;
            hi += (p[0] === 1'b1) ? 1 : 0;
            neq += (led_out !== {4{led_out[0]}}) ? 1 : 0;
            for (int k = 1; k < 4; k++)
                if (rs[k] == 0 && led_out[k] === 1'b1 && p[k] === 1'b0) rs[k] = per;
        end while (!(led_out[0] === 1'b1 && p[0] === 1'b0) && per < 40000);
        @(posedge clk_in);
    endtask
    // Period and duty from frequency code, multiplier and resolution
    task automatic led_case(input int c, input int m, input bit ph);
        int per, hi, neq, ep, eh;
        int rs[4];
        ep = 250000000 / (BPB_FREQ_HZ[c] << m);
        eh = ((TGT >> (16 - BPB_RES[c])) * 250) / (5 << m);
        meas(per, hi, neq, rs);
        `CHK(per > ep - 100 && per < ep + 100, 1'b1)
        `CHK(hi > eh - 60 && hi < eh + 60, 1'b1)
        if (ph) begin
            for (int k = 1; k < 4; k++)
                `CHK(rs[k] * 4 > k * per - 240 && rs[k] * 4 < k * per + 240, 1'b1)
        end else begin
            `CHK(neq, 0)
        end
        $display("test led code %0d mult %0d phase %0d done", c, m, ph);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        int n, e;
        logic [4:0] codes[5];
        codes = '{5'h00, 5'h01, 5'h1d, 5'h1e, 5'h1f};
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        // Reset contents, plain storage, lane and unmapped handling
        bus(1'b0, 6'h00, 32'h0, 4'h1, r); `CHK(r[7:0], 8'h80)
        bus(1'b0, 6'h04, 32'h0, 4'h1, r); `CHK(r[7:0], 8'h00)
        wr(6'h14, 32'ha5, 4'h1);
        wr(6'h18, 32'h5a, 4'h0);
        bus(1'b0, 6'h14, 32'h0, 4'h1, r); `CHK(r[7:0], 8'ha5)
        bus(1'b0, 6'h18, 32'h0, 4'h1, r); `CHK(r[7:0], 8'h00)
        wr(6'h2c, 32'hffff_ffff, 4'hf);
        bus(1'b0, 6'h2c, 32'h0, 4'hf, r); `CHK(r, 32'h0)
        $display("test registers done");
        // Boost start and manual voltage codes
        backlight_enable_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        `CHK(boost_run_out, 1'b0)
        wr(6'h04, 32'h80, 4'h1);
        repeat (20) @(posedge clk_in);
        `CHK(boost_run_out, 1'b1)
        foreach (codes[i]) begin
            wr(6'h08, {27'h0, codes[i]}, 4'h1);
            repeat (4) @(posedge clk_in);
            e = (codes[i] < 5'd30 ? 10 + int'(codes[i]) : 40) * BPB_UNITS_PER_V;
            `CHK(boost_target_out, 9'(e))
            bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[25:16], {1'b1, 9'(e)})
        end
        for (int s = 0; s < 4; s++) begin
            wr(6'h0c, 32'(s), 4'h1);
            bclk(n);
            bclk(n); `CHK(n, (4 << s) * BPB_INT_DIV)
        end
        backlight_enable_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        `CHK(boost_run_out, 1'b0)
        // Adaptive start loads the manual code
        wr(6'h0c, 32'h04, 4'h1);
        wr(6'h08, 32'h00, 4'h1);
        backlight_enable_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK(boost_target_out, 9'(BPB_VMIN_V * BPB_UNITS_PER_V))
        $display("test boost done");
        // LED PWM from register brightness, code source then resistor
        wr(6'h0c, 32'h10, 4'h1);
        wr(6'h00, 32'hbf, 4'h1);
        wr(6'h04, 32'h00, 4'h1);
        wr(6'h20, TGT, 4'h3);
        bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[26], 1'b1)
        `CHK(r[15:0], 16'(TGT))
        led_case(31, 1, 1'b0);
        wr(6'h00, 32'h9f, 4'h1);
        wr(6'h04, 32'h01, 4'h1);
        led_case(31, 0, 1'b1);
        frequency_set_resistor_in <= 3'h1;
        wr(6'h00, 32'h60, 4'h1);
        led_case(7, 3, 1'b1);
        // Slowest slope: one LSB up, then down, in the same time
        e = BPB_SLOPE_MS[15] * (BPB_INT_HZ / 1000) / BPB_BRIGHT_FS;
        wr(6'h04, 32'h7f, 4'h1);
        wr(6'h20, TGT + 1, 4'h3);
        repeat ((e - 8) * BPB_INT_DIV) @(posedge clk_in);
        bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[26], 1'b0)
        repeat (15 * BPB_INT_DIV) @(posedge clk_in);
        bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[15:0], 16'(TGT + 1))
        wr(6'h20, TGT, 4'h3);
        repeat ((e - 8) * BPB_INT_DIV) @(posedge clk_in);
        bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[26], 1'b0)
        repeat (15 * BPB_INT_DIV) @(posedge clk_in);
        bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[15:0], 16'(TGT))
        $display("test slope done");
        // Direct mode follows the input on all channels together
        wr(6'h0c, 32'h18, 4'h1);
        pwm_direct_in <= 1'b1;
        repeat (200) @(posedge clk_in);
        `CHK(led_out, 4'hf)
        pwm_direct_in <= 1'b0;
        repeat (200) @(posedge clk_in);
        `CHK(led_out, 4'h0)
        bus(1'b0, 6'h24, 32'h0, 4'hf, r); `CHK(r[27], 1'b1)
        $display("test direct done");
        tally_and_finish();
    end
endmodule
